/* rtl/ifs_top.sv */
// interlock and field pair selector top with apb register slave
// Functional notes
// - start interlock keeps outputs off until reset
// - restart lockout holds off until reset press
// - restart lockout implies start interlock too
// - automatic restart releases when field clears
// - pairs switchable whenever operation allows
// - changeover violation flags fault, that function's output off
// - fixed, overlapped and fixed-moment activation modes
// - old pair monitored during changeover
// - occupied target adds sync delay to response
// - fixed mode always monitors first pair
// - overlapped mode needs at most five pairs
// - overlapped: two pairs max, only selected ones
// - second pair starts timer, one left after
// - first group decodes one-hot or one-cold for function a
// - second group selects function b pairs
// - fixed moment: timer on change, then switch
`timescale 1ns/10ps
`include "ifs_defs.svh"
module ifs_top import ifs_pkg::*; #(
	parameter int unsigned BTN_MIN_CYC = `IFS_BTN_MIN_CYC,
	parameter int unsigned BTN_MAX_CYC = `IFS_BTN_MAX_CYC,
	parameter int unsigned SYNC_CYC = `IFS_SYNC_CYC
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// machine control: bit 0 is field_select_in_first, bit 9 field_select_in_tenth
	input wire logic [9:0] field_select_in,
	input wire logic reset_button,
	// protective field occupancy per pair from the scan evaluation
	input wire logic [9:0] pf_occupied_a,
	input wire logic [9:0] pf_occupied_b,
	// safety outputs and monitoring state
	output logic ossd_a,
	output logic ossd_b,
	output logic [9:0] monitor_a,
	output logic [9:0] monitor_b,
	output logic fault
);
	typedef struct packed {
		logic [31:0] ctrl;
		logic [31:0] chg_time;
		logic [31:0] resp_time;
		logic [31:0] pair_cfg;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic fault_clear;
		ifs_ilk_e ilk_a;
		ifs_ilk_e ilk_b;
		logic [1:0][31:0] viol;
		logic [1:0] ext;
		logic ossd_a;
		logic ossd_b;
		logic fault;
	} ifs_top_s;

	localparam ifs_top_s RST = '{ctrl: `IFS_CTRL_RST, chg_time: `IFS_CHG_TIME_RST,
		resp_time: `IFS_RESP_TIME_RST, pair_cfg: `IFS_PAIR_CFG_RST, prdata: 32'h0,
		pready: 1'b0, pslverr: 1'b0, fault_clear: 1'b0, ilk_a: ILK_POWERUP, ilk_b: ILK_POWERUP,
		viol: '0, ext: 2'b00, ossd_a: 1'b0, ossd_b: 1'b0, fault: 1'b0};

	ifs_top_s s;
	ifs_top_s next_s;

	logic accept;
	logic [9:0] mon_a;
	logic [9:0] mon_b;
	logic chg_a;
	logic chg_b;
	logic fault_a;
	logic fault_b;
	logic [2:0] diag_a;
	logic [2:0] diag_b;
	logic [1:0] occ;
	logic [1:0] chg;
	logic [1:0] trip;
	logic [31:0] limit;
	logic [31:0] rd;
	logic rd_err;
	logic two_func;
	// access phase: first cycle raises pready, second commits the write
	logic acc_first;
	logic acc_last;
	logic [2:0] ridx;
	ifs_fmode_e fmode_a;
	ifs_fmode_e fmode_b;

	// an illegal field mode code passes through so the selector can flag it
	assign fmode_a = ifs_fmode_e'(s.ctrl[`IFS_CTRL_FMODE_A +: 2]);
	assign fmode_b = ifs_fmode_e'(s.ctrl[`IFS_CTRL_FMODE_B +: 2]);

	ifs_button #(
		.MIN_CYC(BTN_MIN_CYC),
		.MAX_CYC(BTN_MAX_CYC)
	) u_button (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.button(reset_button),
		.accept(accept)
	);

	ifs_field_sel u_sel_a (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.fmode(fmode_a),
		.cfg_pairs(s.pair_cfg[9:0]),
		.chg_time(s.chg_time),
		.fault_clear(s.fault_clear),
		.sel(field_select_in[4:0]),
		.monitor(mon_a),
		.changed(chg_a),
		.fault(fault_a),
		.diag(diag_a)
	);

	ifs_field_sel u_sel_b (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.fmode(fmode_b),
		.cfg_pairs(s.pair_cfg[`IFS_PAIR_CFG_B +: 10]),
		.chg_time(s.chg_time),
		.fault_clear(s.fault_clear),
		.sel(field_select_in[9:5]),
		.monitor(mon_b),
		.changed(chg_b),
		.fault(fault_b),
		.diag(diag_b)
	);

	// byte-lane merge of a write into a stored word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// register index of a byte address; unmapped words give 3'h7
	function automatic logic [2:0] reg_index(input logic [7:0] a);
		logic [2:0] r;
		r = 3'h7;
		unique case (a)
			`IFS_OFF_CTRL: r = 3'h0;
			`IFS_OFF_CHG_TIME: r = 3'h1;
			`IFS_OFF_RESP_TIME: r = 3'h2;
			`IFS_OFF_PAIR_CFG: r = 3'h3;
			`IFS_OFF_STATUS: r = 3'h4;
			default: r = 3'h7;
		endcase
		return r;
	endfunction

	// status word: outputs, faults, monitored pairs and diagnosis per function
	function automatic logic [31:0] status_word(input logic oa, input logic ob, input logic fa, input logic fb,
		input logic [9:0] ma, input logic [9:0] mb, input logic [2:0] da, input logic [2:0] db);
		logic [31:0] w;
		w = 32'h0;
		w[0] = oa;
		w[1] = ob;
		w[2] = fa;
		w[3] = fb;
		w[13:4] = ma;
		w[23:14] = mb;
		w[26:24] = da;
		w[29:27] = db;
		return w;
	endfunction

	// one interlock step for a protective function
	function automatic ifs_ilk_e ilk_step(input ifs_ilk_e cur, input logic [1:0] smode, input logic busy,
		input logic tripped, input logic acc, input logic flt);
		ifs_ilk_e r;
		r = cur;
		if (flt) begin
			r = ILK_FAULT;
		end else begin
			unique case (cur)
				ILK_POWERUP: begin
					if (smode == SM_AUTO) begin
						r = ILK_TRIP;
					end else begin
						r = ILK_LOCKED;
					end
				end
				ILK_LOCKED: begin
					if (acc && !busy) begin
						r = ILK_RUN;
					end
				end
				ILK_RUN: begin
					if (tripped) begin
						r = ILK_TRIP;
					end
				end
				ILK_TRIP: begin
					if (!busy && smode == SM_RESTART) begin
						r = ILK_LOCKED;
					end else if (!busy) begin
						r = ILK_RUN;
					end
				end
				ILK_FAULT: begin
					// after a cleared fault only auto mode may resume without the button
					if (smode == SM_AUTO) begin
						r = ILK_TRIP;
					end else begin
						r = ILK_LOCKED;
					end
				end
				default: begin
					r = ILK_LOCKED;
				end
			endcase
		end
		return r;
	endfunction

	always_comb begin
		next_s = s;
		two_func = s.ctrl[`IFS_CTRL_TWO_FUNC];
		occ[0] = |(mon_a & pf_occupied_a);
		occ[1] = |(mon_b & pf_occupied_b);
		chg[0] = chg_a;
		chg[1] = chg_b;
		trip = 2'b00;
		limit = 32'h0;
		for (int i = 0; i < 2; i++) begin
			if (!occ[i]) begin
				next_s.ext[i] = 1'b0;
				next_s.viol[i] = 32'h0;
			end else begin
				// switched straight into an occupied field: extend by the sync time
				if (chg[i] && s.viol[i] == 32'h0) begin
					next_s.ext[i] = 1'b1;
				end
				limit = s.resp_time + (next_s.ext[i] ? SYNC_CYC : 32'h0);
				if (s.viol[i] >= limit) begin
					trip[i] = 1'b1;
				end else begin
					next_s.viol[i] = s.viol[i] + 32'h1;
				end
			end
		end
		next_s.ilk_a = ilk_step(s.ilk_a, s.ctrl[`IFS_CTRL_SMODE_A +: 2], occ[0], trip[0], accept, fault_a);
		next_s.ilk_b = ilk_step(s.ilk_b, s.ctrl[`IFS_CTRL_SMODE_B +: 2], occ[1], trip[1], accept, fault_b);
		next_s.ossd_a = (next_s.ilk_a == ILK_RUN);
		next_s.ossd_b = (next_s.ilk_b == ILK_RUN) && two_func;
		next_s.fault = fault_a || (fault_b && two_func);

		// read data is prepared in the first access cycle and shown with pready
		acc_first = psel && penable && !s.pready;
		acc_last = psel && penable && s.pready;
		ridx = reg_index(paddr);
		rd = 32'h0;
		rd_err = 1'b0;
		unique case (ridx)
			3'h0: begin
				rd = s.ctrl;
			end
			3'h1: begin
				rd = s.chg_time;
			end
			3'h2: begin
				rd = s.resp_time;
			end
			3'h3: begin
				rd = s.pair_cfg;
			end
			3'h4: begin
				rd = status_word(s.ossd_a, s.ossd_b, fault_a, fault_b, mon_a, mon_b, diag_a, diag_b);
			end
			default: begin
				rd_err = 1'b1;
			end
		endcase
		next_s.fault_clear = 1'b0;
		next_s.pready = acc_first;
		if (acc_first) begin
			next_s.prdata = pwrite ? 32'h0 : rd;
			next_s.pslverr = rd_err;
		end else begin
			next_s.pslverr = 1'b0;
		end
		// an errored write is dropped; status writes are ignored without an error
		if (acc_last && pwrite && !s.pslverr) begin
			unique case (ridx)
				3'h0: begin
					next_s.ctrl = merge(s.ctrl, pwdata, pstrb) & `IFS_CTRL_MASK;
					next_s.fault_clear = pwdata[`IFS_CTRL_FAULT_CLR] && pstrb[1];
				end
				3'h1: begin
					next_s.chg_time = merge(s.chg_time, pwdata, pstrb);
				end
				3'h2: begin
					next_s.resp_time = merge(s.resp_time, pwdata, pstrb);
				end
				3'h3: begin
					next_s.pair_cfg = merge(s.pair_cfg, pwdata, pstrb) & 32'h03ff_03ff;
				end
				default: begin
					next_s.pair_cfg = s.pair_cfg;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			s <= RST;
		end else begin
			s <= next_s;
		end
	end

	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign ossd_a = s.ossd_a;
	assign ossd_b = s.ossd_b;
	assign monitor_a = mon_a;
	assign monitor_b = mon_b;
	assign fault = s.fault;
endmodule

/* rtl/ifs_defs.svh */
// constants for the interlock and field selector: offsets, fields, reset values, timing
`ifndef IFS_DEFS_SVH
`define IFS_DEFS_SVH

`define IFS_CLK_KHZ 40000
`define IFS_BTN_MIN_MS 120
`define IFS_BTN_MAX_MS 4000
`define IFS_SYNC_MS 40
`define IFS_BTN_MIN_CYC (`IFS_BTN_MIN_MS * `IFS_CLK_KHZ)
`define IFS_BTN_MAX_CYC (`IFS_BTN_MAX_MS * `IFS_CLK_KHZ)
`define IFS_SYNC_CYC (`IFS_SYNC_MS * `IFS_CLK_KHZ)

`define IFS_OFF_CTRL 8'h00
`define IFS_OFF_CHG_TIME 8'h04
`define IFS_OFF_RESP_TIME 8'h08
`define IFS_OFF_PAIR_CFG 8'h0c
`define IFS_OFF_STATUS 8'h10

`define IFS_CTRL_SMODE_A 0
`define IFS_CTRL_SMODE_B 2
`define IFS_CTRL_FMODE_A 4
`define IFS_CTRL_FMODE_B 6
`define IFS_CTRL_TWO_FUNC 8
`define IFS_CTRL_FAULT_CLR 9
`define IFS_CTRL_MASK 32'h0000_01ff
`define IFS_PAIR_CFG_B 16

`define IFS_CTRL_RST 32'h0000_000a
`define IFS_CHG_TIME_RST 32'h0000_9c40
`define IFS_RESP_TIME_RST 32'h0002_7100
`define IFS_PAIR_CFG_RST 32'h001f_001f

`endif

/* rtl/ifs_pkg.sv */
// types shared by the interlock and field selector modules
package ifs_pkg;
	typedef enum logic [1:0] {
		SM_AUTO = 2'b00,
		SM_START = 2'b01,
		SM_RESTART = 2'b10
	} ifs_smode_e;

	typedef enum logic [1:0] {
		FM_FIXED = 2'b00,
		FM_OVERLAP = 2'b01,
		FM_MOMENT = 2'b10
	} ifs_fmode_e;

	typedef enum logic [2:0] {
		ILK_POWERUP = 3'b000,
		ILK_LOCKED = 3'b001,
		ILK_RUN = 3'b010,
		ILK_TRIP = 3'b011,
		ILK_FAULT = 3'b100
	} ifs_ilk_e;

	typedef enum logic [2:0] {
		DG_NONE = 3'b000,
		DG_MODE = 3'b001,
		DG_MULTI = 3'b010,
		DG_TIMEOUT = 3'b011,
		DG_UNCONF = 3'b100
	} ifs_diag_e;
endpackage

/* rtl/ifs_button.sv */
// reset button hold-time qualifier
`timescale 1ns/10ps
`include "ifs_defs.svh"
module ifs_button import ifs_pkg::*; #(
	parameter int unsigned MIN_CYC = `IFS_BTN_MIN_CYC,
	parameter int unsigned MAX_CYC = `IFS_BTN_MAX_CYC
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// button level and qualified release
	input wire logic button,
	output logic accept
);
	typedef struct packed {
		logic [31:0] hold;
		logic pressed;
		logic accept;
	} ifs_btn_s;

	ifs_btn_s s;
	ifs_btn_s next_s;

	always_comb begin
		next_s = s;
		next_s.pressed = button;
		next_s.accept = 1'b0;
		if (button) begin
			// saturate just past the window so a long press never wraps into it
			if (s.hold <= MAX_CYC) begin
				next_s.hold = s.hold + 32'h1;
			end
		end else begin
			if (s.pressed) begin
				next_s.accept = (s.hold >= MIN_CYC) && (s.hold <= MAX_CYC);
			end
			next_s.hold = 32'h0;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign accept = s.accept;
endmodule

/* rtl/ifs_field_sel.sv */
// field pair selection and changeover checking for one protective function
`timescale 1ns/10ps
`include "ifs_defs.svh"
module ifs_field_sel import ifs_pkg::*; (
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// configuration
	input wire ifs_fmode_e fmode,
	input wire logic [9:0] cfg_pairs,
	input wire logic [31:0] chg_time,
	input wire logic fault_clear,
	// select inputs, first to fifth of the group
	input wire logic [4:0] sel,
	// monitored pairs and fault
	output logic [9:0] monitor,
	output logic changed,
	output logic fault,
	output logic [2:0] diag
);
	typedef struct packed {
		logic [4:0] prev;
		logic [31:0] timer;
		logic timing;
		logic [9:0] monitor;
		logic changed;
		logic fault;
		ifs_diag_e diag;
	} ifs_fsel_s;

	localparam ifs_fsel_s RST = '{prev: 5'h00, timer: 32'h0, timing: 1'b1, monitor: 10'h001,
		changed: 1'b0, fault: 1'b0, diag: DG_NONE};

	ifs_fsel_s s;
	ifs_fsel_s next_s;
	logic raise;
	ifs_diag_e code;
	logic [9:0] dec;

	function automatic logic [9:0] decode_pair(input logic [4:0] v);
		logic [9:0] r;
		r = 10'h000;
		unique case (v)
			5'b00001: r = 10'h001;
			5'b00010: r = 10'h002;
			5'b00100: r = 10'h004;
			5'b01000: r = 10'h008;
			5'b10000: r = 10'h010;
			5'b01111: r = 10'h020;
			5'b10111: r = 10'h040;
			5'b11011: r = 10'h080;
			5'b11101: r = 10'h100;
			5'b11110: r = 10'h200;
			default: r = 10'h000;
		endcase
		return r;
	endfunction

	function automatic logic [2:0] count_ones(input logic [4:0] v);
		logic [2:0] c;
		c = 3'h0;
		for (int i = 0; i < 5; i++) begin
			c = c + {2'h0, v[i]};
		end
		return c;
	endfunction

	always_comb begin
		next_s = s;
		raise = 1'b0;
		code = DG_NONE;
		dec = decode_pair(sel) & cfg_pairs;
		next_s.prev = sel;
		unique case (fmode)
			FM_FIXED: begin
				next_s.monitor = 10'h001;
				next_s.timing = 1'b0;
				next_s.timer = 32'h0;
			end
			FM_OVERLAP: begin
				// more than two selects: keep only old pairs still selected, never a third
				if (count_ones(sel) > 3'd2) begin
					next_s.monitor = s.monitor & {5'h00, sel};
				end else begin
					next_s.monitor = {5'h00, sel & cfg_pairs[4:0]};
				end
				if (|cfg_pairs[9:5]) begin
					raise = 1'b1;
					code = DG_MODE;
				end else if (count_ones(sel) > 3'd2) begin
					raise = 1'b1;
					code = DG_MULTI;
				end
				if (count_ones(sel) == 3'd1 && |(sel & cfg_pairs[4:0])) begin
					next_s.timing = 1'b0;
					next_s.timer = 32'h0;
				end else if (s.timer >= chg_time) begin
					raise = 1'b1;
					code = (count_ones(sel) == 3'd2) ? DG_TIMEOUT : DG_UNCONF;
				end else begin
					next_s.timing = 1'b1;
					next_s.timer = s.timer + 32'h1;
				end
			end
			FM_MOMENT: begin
				if (sel != s.prev) begin
					next_s.timing = 1'b1;
					next_s.timer = 32'h0;
				end else if (s.timing) begin
					if (s.timer >= chg_time) begin
						next_s.timing = 1'b0;
						if (dec == 10'h000) begin
							raise = 1'b1;
							code = DG_UNCONF;
						end else begin
							next_s.monitor = dec;
						end
					end else begin
						next_s.timer = s.timer + 32'h1;
					end
				end
			end
			default: begin
				raise = 1'b1;
				code = DG_MODE;
			end
		endcase
		next_s.changed = next_s.monitor != s.monitor;
		// a new violation beats a clear in the same cycle
		if (raise) begin
			next_s.fault = 1'b1;
			next_s.diag = code;
		end else if (fault_clear) begin
			next_s.fault = 1'b0;
			next_s.diag = DG_NONE;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			s <= RST;
		end else begin
			s <= next_s;
		end
	end

	assign monitor = s.monitor;
	assign changed = s.changed;
	assign fault = s.fault;
	assign diag = s.diag;
endmodule

/* tb/ifs_chk.sv */
// assertion checker for the interlock and field selector top
`timescale 1ns/10ps
module ifs_chk (
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// apb handshake
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	// field state and outputs
	input wire logic [9:0] pf_occupied_a,
	input wire logic ossd_a,
	input wire logic ossd_b,
	input wire logic [9:0] monitor_a,
	input wire logic [9:0] monitor_b,
	input wire logic fault
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	pwr_lock_a: assert property ($rose(resetn) |-> !ossd_a && !ossd_b)
		else $error("outputs on straight after reset");
	fault_off_a: assert property (fault [*2] |-> !ossd_a || !ossd_b)
		else $error("output on while fault stands");
	two_pairs_a: assert property ($countones(monitor_a) <= 2 && $countones(monitor_b) <= 2)
		else $error("more than two pairs monitored");
	free_start_a: assert property ($rose(ossd_a) |-> (monitor_a & pf_occupied_a) == 10'h000 && !fault)
		else $error("output released into occupied field");
	// bound covers response plus sync delay at the bench settings
	occ_trip_a: assert property (ossd_a && (monitor_a & pf_occupied_a) != 10'h000 |-> ##[1:40] !ossd_a)
		else $error("no trip on occupied field");
	apb_wait_a: assert property (psel && penable && !pready |=> pready)
		else $error("apb answer late");
	apb_pulse_a: assert property (pready |=> !pready)
		else $error("apb ready longer than one cycle");
	err_ready_a: assert property (pslverr |-> pready && psel)
		else $error("slave error without ready");
	cover property ($rose(ossd_a));
	cover property ($rose(fault));
	cover property ($countones(monitor_a) == 2);
endmodule

bind ifs_top ifs_chk chk_u (.sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable), .pready(pready),
	.pslverr(pslverr), .pf_occupied_a(pf_occupied_a), .ossd_a(ossd_a), .ossd_b(ossd_b), .monitor_a(monitor_a),
	.monitor_b(monitor_b), .fault(fault));

/* tb/ifs_mcs_model.sv */
// machine control model driving the field selects and the reset button
`timescale 1ns/10ps
module ifs_mcs_model (
	// clock
	input wire logic sys_clk,
	// control lines towards the scanner
	output logic [9:0] field_select_in,
	output logic reset_button
);
	initial begin
		field_select_in = 10'h021;
		reset_button = 1'b0;
	end
	// hold for cyc clocks; short or long holds model a misused button
	task automatic press(input int cyc);
		reset_button <= 1'b1;
		repeat (cyc) @(posedge sys_clk);
		reset_button <= 1'b0;
	endtask
	// new pair joins first, old one leaves after lag clocks
	task automatic overlap(input logic [9:0] nxt, input int lag);
		field_select_in <= field_select_in | nxt;
		repeat (lag) @(posedge sys_clk);
		field_select_in <= nxt;
	endtask
	// direct change, also used for deliberate misuse
	task automatic set(input logic [9:0] val);
		field_select_in <= val;
		@(posedge sys_clk);
	endtask
endmodule

/* tb/test_interlock_and_field_selector.sv */
// self-checking bench for the interlock and field selector top
`timescale 1ns/10ps
`include "ifs_defs.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module test_interlock_and_field_selector;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'hf;
	logic [31:0] prdata, rd;
	logic pready, pslverr, ossd_a, ossd_b, fault, reset_button;
	logic [9:0] field_select_in, monitor_a, monitor_b;
	logic [9:0] pf_occupied_a = 10'h000;
	logic [9:0] pf_occupied_b = 10'h000;
	logic [31:0] rst [4] = '{`IFS_CTRL_RST, `IFS_CHG_TIME_RST, `IFS_RESP_TIME_RST, `IFS_PAIR_CFG_RST};
	int fails = 0;
	int n_tests = 0;
	always #12.5 sys_clk = ~sys_clk;
	// long counts shortened so the run stays brief
	ifs_top #(.BTN_MIN_CYC(10), .BTN_MAX_CYC(100), .SYNC_CYC(20)) dut_u (.sys_clk(sys_clk), .resetn(resetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .field_select_in(field_select_in),
		.reset_button(reset_button), .pf_occupied_a(pf_occupied_a), .pf_occupied_b(pf_occupied_b), .ossd_a(ossd_a),
		.ossd_b(ossd_b), .monitor_a(monitor_a), .monitor_b(monitor_b), .fault(fault));
	ifs_mcs_model mcs_u (.sys_clk(sys_clk), .field_select_in(field_select_in), .reset_button(reset_button));
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// one apb transfer; idle edge after it so psel is never set twice at once
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic err);
		int k;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge sys_clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rd = prdata;
		`CHK("pslverr", err, pslverr)
		if (pready !== 1'b1) begin
			fails++;
			print_verdict();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask
	function automatic logic pick(input string nm);
		return (nm == "fault") ? fault : (nm == "ossd_b") ? ossd_b : ossd_a;
	endfunction
	task automatic wt(input string nm, input logic v, input int n);
		for (int k = 0; k < n && pick(nm) !== v; k++) @(posedge sys_clk);
		`CHK(nm, v, pick(nm))
	endtask
	initial begin
		repeat (2) @(posedge sys_clk);
		resetn <= 1'b1;
		@(posedge sys_clk);
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, 8'(4 * i), 32'h0, 1'b0);
			`CHK("reg reset", rst[i], rd)
		end
		pstrb <= 4'h5;
		apb(1'b1, `IFS_OFF_RESP_TIME, 32'haaaa_aaaa, 1'b0);
		pstrb <= 4'ha;
		apb(1'b1, `IFS_OFF_RESP_TIME, 32'h5555_5555, 1'b0);
		pstrb <= 4'hf;
		apb(1'b0, `IFS_OFF_RESP_TIME, 32'h0, 1'b0);
		`CHK("resp_time", 32'h55aa_55aa, rd)
		apb(1'b1, 8'h20, 32'h0, 1'b1);
		apb(1'b1, `IFS_OFF_CHG_TIME, 32'h14, 1'b0);
		apb(1'b1, `IFS_OFF_RESP_TIME, 32'h0a, 1'b0);
		mcs_u.set(10'h024);
		repeat (30) @(posedge sys_clk);
		`CHK("ossd_a", 1'b0, ossd_a)
		mcs_u.press(5);
		repeat (5) @(posedge sys_clk);
		`CHK("ossd_a", 1'b0, ossd_a)
		mcs_u.press(20);
		wt("ossd_a", 1'b1, 5);
		`CHK("monitor_a", 10'h001, monitor_a)
		pf_occupied_a <= 10'h001;
		wt("ossd_a", 1'b0, 40);
		pf_occupied_a <= 10'h000;
		repeat (20) @(posedge sys_clk);
		`CHK("ossd_a", 1'b0, ossd_a)
		mcs_u.press(20);
		wt("ossd_a", 1'b1, 5);
		apb(1'b1, `IFS_OFF_CTRL, 32'h18, 1'b0);
		pf_occupied_a <= 10'h004;
		wt("ossd_a", 1'b0, 40);
		pf_occupied_a <= 10'h000;
		wt("ossd_a", 1'b1, 10);
		for (int n = 0; n < 5; n++) begin
			mcs_u.overlap({5'b00001, 5'(1 << n)}, 3);
			repeat (3) @(posedge sys_clk);
			`CHK("monitor_a", 10'(1 << n), monitor_a)
		end
		`CHK("fault", 1'b0, fault)
		mcs_u.set(10'h031);
		repeat (3) @(posedge sys_clk);
		`CHK("monitor_a", 10'h011, monitor_a)
		wt("fault", 1'b1, 30);
		`CHK("ossd_a", 1'b0, ossd_a)
		apb(1'b0, `IFS_OFF_STATUS, 32'h0, 1'b0);
		`CHK("diag_a", 3'h3, rd[26:24])
		mcs_u.set(10'h030);
		apb(1'b1, `IFS_OFF_CTRL, 32'h218, 1'b0);
		wt("fault", 1'b0, 5);
		wt("ossd_a", 1'b1, 10);
		mcs_u.set(10'h027);
		wt("fault", 1'b1, 3);
		apb(1'b0, `IFS_OFF_STATUS, 32'h0, 1'b0);
		`CHK("diag_a", 3'h2, rd[26:24])
		mcs_u.set(10'h030);
		apb(1'b1, `IFS_OFF_CTRL, 32'h218, 1'b0);
		wt("ossd_a", 1'b1, 10);
		pf_occupied_a <= 10'h001;
		mcs_u.overlap(10'h021, 2);
		repeat (15) @(posedge sys_clk);
		`CHK("ossd_a", 1'b1, ossd_a)
		wt("ossd_a", 1'b0, 25);
		pf_occupied_a <= 10'h000;
		apb(1'b1, `IFS_OFF_PAIR_CFG, 32'h001f_03ff, 1'b0);
		wt("fault", 1'b1, 5);
		apb(1'b1, `IFS_OFF_CTRL, 32'h28, 1'b0);
		apb(1'b1, `IFS_OFF_CTRL, 32'h228, 1'b0);
		wt("fault", 1'b0, 5);
		repeat (25) @(posedge sys_clk);
		mcs_u.set(10'h02f);
		repeat (10) @(posedge sys_clk);
		`CHK("monitor_a", 10'h001, monitor_a)
		repeat (15) @(posedge sys_clk);
		`CHK("monitor_a", 10'h020, monitor_a)
		mcs_u.set(10'h023);
		repeat (10) @(posedge sys_clk);
		`CHK("fault", 1'b0, fault)
		wt("fault", 1'b1, 20);
		apb(1'b0, `IFS_OFF_STATUS, 32'h0, 1'b0);
		`CHK("diag_a", 3'h4, rd[26:24])
		mcs_u.set(10'h021);
		apb(1'b1, `IFS_OFF_CTRL, 32'h160, 1'b0);
		apb(1'b1, `IFS_OFF_CTRL, 32'h360, 1'b0);
		wt("fault", 1'b0, 5);
		mcs_u.overlap(10'h081, 3);
		repeat (3) @(posedge sys_clk);
		`CHK("monitor_b", 10'h004, monitor_b)
		`CHK("ossd_b", 1'b1, ossd_b)
		pf_occupied_b <= 10'h3fb;
		repeat (20) @(posedge sys_clk);
		`CHK("ossd_b", 1'b1, ossd_b)
		pf_occupied_b <= 10'h3ff;
		wt("ossd_b", 1'b0, 40);
		pf_occupied_b <= 10'h000;
		wt("ossd_b", 1'b1, 10);
		print_verdict();
	end
endmodule
